//--- sirq_enable_pkg.sv
// constants shared by the serial interrupt enable block
package sirq_enable_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses, one aligned word each)
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;                              // decoded address bits
    localparam logic [7:0] OFS_SERIAL_IRQ_CONTROL_ONE = 8'h00; // enable register
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h04;          // read-only state view

    // ------------------------------------------------------------
    // enable register field positions
    // ------------------------------------------------------------
    localparam int CH3_IRQ11_ENABLE = 7;                    // channel 3 to irq11
    localparam int CH3_IRQ10_ENABLE = 6;                    // channel 3 to irq10
    localparam int CH3_IRQ9_ENABLE = 5;                     // channel 3 to irq9
    localparam int CH3_IRQ6_ENABLE = 4;                     // channel 3 to irq6
    localparam int CH2_IRQ11_ENABLE = 3;                    // channel 2 to irq11
    localparam int EN_LOW = 3;                              // lowest implemented bit
    localparam int EN_HIGH = 7;                             // highest implemented bit

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [7:0] SERIAL_IRQ_CONTROL_ONE_RESET = 8'h00; // all enables off
    localparam logic [31:0] RDATA_RESET = 32'h00000000;     // read bus idle value

    // ------------------------------------------------------------
    // request vector positions and status register layout
    // ------------------------------------------------------------
    localparam int REQ_IRQ6 = 0;                            // request index irq6
    localparam int REQ_IRQ9 = 1;                            // request index irq9
    localparam int REQ_IRQ10 = 2;                           // request index irq10
    localparam int REQ_IRQ11 = 3;                           // request index irq11
    localparam int NUM_REQ = 4;                             // number of host requests
    localparam int ST_CH2_OBF = 0;                          // status: channel 2 flag
    localparam int ST_CH3_OBF = 1;                          // status: channel 3 flag
    localparam int ST_REQ_LSB = 4;                          // status: requests [7:4]
    localparam int ST_LPC_RESET = 8;                        // status: lpc reset active

    // ------------------------------------------------------------
    // bus encodings
    // ------------------------------------------------------------
    localparam logic HRESP_OKAY = 1'b0;                     // only response used

endpackage

//--- level_sync.sv
// two flip-flop level synchroniser, one lane per bit
`timescale 1ns/1ns
`default_nettype none

module level_sync
    import sirq_enable_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // destination clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // levels from the foreign domain
    input wire logic [WIDTH-1:0] async_in,
    // levels safe to use in the clk domain
    output logic [WIDTH-1:0] sync_out
);

    // both stages of every lane in one state word
    typedef struct packed {
        logic [WIDTH-1:0] stage1; // metastability catcher, read by stage2 only
        logic [WIDTH-1:0] stage2; // settled copy
    } sync_state_t;

    sync_state_t state;
    sync_state_t next_state;

    // ------------------------------------------------------------
    // per-lane shift
    // ------------------------------------------------------------
    // lanes are independent: a multi-bit value may arrive skewed by one cycle
    always_comb begin
        next_state = state;
        next_state.stage1 = async_in;
        next_state.stage2 = state.stage1;
    end

    // register the copy; reset loads constants only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign sync_out = state.stage2;

endmodule

`default_nettype wire

//--- sirq_enable.sv
// host serial interrupt enables for channels 2 and 3, with an ahb-lite register slave
//
// Operation
// - ch3 flag set, bit7 on requests irq11
// - ch3 flag set, bit6 on requests irq10
// - ch3 flag set, bit5 on requests irq9
// - ch3 flag set, bit4 on requests irq6
// - ch2 flag set, bit3 on requests irq11
// - direct mode: enable bit alone requests
// - enable bit zero suppresses its request
// - writing zero clears the enable bit
// - lpc hardware or software reset clears enables
// - flag clear clears enable unless direct mode
// - set only by writing one after reading zero
`timescale 1ns/1ns
`default_nettype none

module sirq_enable
    import sirq_enable_pkg::*;
(
    // system clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave port
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // output-buffer-full flags and mode from the host interface core
    input wire logic ch3_out_buffer_full,
    input wire logic ch2_out_buffer_full,
    input wire logic interrupt_direct_mode,
    // lpc link clock and resets coming from the link side
    input wire logic lclk,
    input wire logic lpc_hw_reset_n,
    input wire logic lpc_sw_reset,
    // host requests toward the serial-irq frame encoder, lclk domain
    output logic host_irq11_req,
    output logic host_irq10_req,
    output logic host_irq9_req,
    output logic host_irq6_req
);

    // ------------------------------------------------------------
    // state of the hclk domain
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] en;             // serial_irq_control_one contents
        logic [7:0] armed;          // bit was read as zero, a one may now land
        logic [1:0] obf_prev;       // last flags, for falling-edge detection
        logic [NUM_REQ-1:0] req;    // combined requests, hclk side
        logic wr_pend;              // write data phase follows
        logic [ADDR_W-1:0] wr_addr; // address of the pending write
        logic [31:0] rdata;         // read data for the data phase
        logic ready;                // hreadyout, never stretched
        logic resp;                 // hresp, always okay
    } state_t;

    state_t state;
    state_t next_state;

    // ------------------------------------------------------------
    // link-side reset crossing
    // ------------------------------------------------------------
    logic [1:0] lpc_rst_raw;    // both lpc resets as active-high levels
    logic [1:0] lpc_rst_sync;   // after two hclk flops
    logic lpc_rst;              // either lpc reset active

    // low-active hardware reset is inverted before sync so idle reads zero
    assign lpc_rst_raw = {lpc_sw_reset, ~lpc_hw_reset_n};

    level_sync #(
        .WIDTH(2)
    ) u_rst_sync (
        .clk(hclk),
        .rst_n(hresetn),
        .async_in(lpc_rst_raw),
        .sync_out(lpc_rst_sync)
    );

    assign lpc_rst = |lpc_rst_sync;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic addr_ok;      // valid address phase accepted this edge
    logic rd_ctl;       // read of the enable register, address phase
    logic wr_ctl;       // write to the enable register, data phase
    logic ch3_fall;     // channel 3 flag just cleared
    logic ch2_fall;     // channel 2 flag just cleared
    logic [7:0] next_en;    // enable vector after this edge
    logic [7:0] clr_vec;    // per-bit clear terms
    logic [7:0] set_vec;    // per-bit set terms
    logic [7:0] fall_vec;   // flag falling edge routed per bit
    logic [31:0] status;    // status register image

    // only htrans nonseq or seq (bit 1 high) starts a transfer
    assign addr_ok = hsel && hready && htrans[1];
    // the host has no path here: only this local bus can set the enables
    assign rd_ctl = addr_ok && !hwrite && (haddr[ADDR_W-1:0] == OFS_SERIAL_IRQ_CONTROL_ONE);
    assign wr_ctl = state.wr_pend && (state.wr_addr == OFS_SERIAL_IRQ_CONTROL_ONE);

    // flags come from logic on hclk, no synchroniser needed
    assign ch3_fall = state.obf_prev[1] && !ch3_out_buffer_full;
    assign ch2_fall = state.obf_prev[0] && !ch2_out_buffer_full;

    // ------------------------------------------------------------
    // per-bit enable update
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_en
            if (i >= EN_LOW && i <= EN_HIGH) begin : g_impl
                // bit 3 follows channel 2, bits 7 to 4 follow channel 3
                assign fall_vec[i] = (i == CH2_IRQ11_ENABLE) ? ch2_fall : ch3_fall;
                // clears: write zero, lpc reset, flag clear outside direct mode
                assign clr_vec[i] = (wr_ctl && !hwdata[i])
                    || lpc_rst
                    || (!interrupt_direct_mode && fall_vec[i]);
                // a one only lands after a read that showed zero
                assign set_vec[i] = wr_ctl && hwdata[i] && state.armed[i];
                // clears win: a reset or flag clear must not be undone by a racing write
                assign next_en[i] = clr_vec[i] ? 1'b0 : (set_vec[i] ? 1'b1 : state.en[i]);
            end else begin : g_rsvd
                // unimplemented bits belong to other blocks and read as zero
                assign fall_vec[i] = 1'b0;
                assign clr_vec[i] = 1'b0;
                assign set_vec[i] = 1'b0;
                assign next_en[i] = 1'b0;
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // status image
    // ------------------------------------------------------------
    always_comb begin
        status = 32'h00000000;
        status[ST_CH2_OBF] = ch2_out_buffer_full;
        status[ST_CH3_OBF] = ch3_out_buffer_full;
        status[ST_REQ_LSB +: NUM_REQ] = state.req;
        status[ST_LPC_RESET] = lpc_rst;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic src3;     // channel 3 source term
    logic src2;     // channel 2 source term

    // direct mode makes the enable itself the request
    assign src3 = interrupt_direct_mode || ch3_out_buffer_full;
    assign src2 = interrupt_direct_mode || ch2_out_buffer_full;

    always_comb begin
        next_state = state;
        next_state.en = next_en;
        next_state.obf_prev = {ch3_out_buffer_full, ch2_out_buffer_full};
        next_state.ready = 1'b1;
        next_state.resp = HRESP_OKAY;
        // arming: a read sets it where the value read is zero, a write consumes it
        // lpc reset drops arming first, so a read racing the reset cannot let a one land just after it
        if (lpc_rst) begin
            next_state.armed = 8'h00;
        end else if (rd_ctl) begin
            // next_en is read so a write just ahead of the read is seen
            next_state.armed = ~next_en;
        end else if (wr_ctl) begin
            next_state.armed = 8'h00;
        end
        // request terms; a zero enable blocks its source
        next_state.req[REQ_IRQ11] = (state.en[CH3_IRQ11_ENABLE] && src3)
            || (state.en[CH2_IRQ11_ENABLE] && src2);
        next_state.req[REQ_IRQ10] = state.en[CH3_IRQ10_ENABLE] && src3;
        next_state.req[REQ_IRQ9] = state.en[CH3_IRQ9_ENABLE] && src3;
        next_state.req[REQ_IRQ6] = state.en[CH3_IRQ6_ENABLE] && src3;
        // address phase capture
        next_state.wr_pend = addr_ok && hwrite;
        next_state.wr_addr = haddr[ADDR_W-1:0];
        // read data is prepared one edge ahead of its data phase
        if (addr_ok && !hwrite) begin
            case (haddr[ADDR_W-1:0])
                OFS_SERIAL_IRQ_CONTROL_ONE: begin
                    next_state.rdata = {24'h000000, next_en};
                end
                OFS_IRQ_STATUS: begin
                    next_state.rdata = status;
                end
                default: begin
                    // unmapped addresses read zero, answer okay
                    next_state.rdata = 32'h00000000;
                end
            endcase
        end else begin
            next_state.rdata = 32'h00000000;
        end
    end

    // register the whole state word
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state.en <= SERIAL_IRQ_CONTROL_ONE_RESET;
            state.armed <= 8'h00;
            state.obf_prev <= 2'h0;
            state.req <= 4'h0;
            state.wr_pend <= 1'b0;
            state.wr_addr <= 8'h00;
            state.rdata <= RDATA_RESET;
            state.ready <= 1'b1;
            state.resp <= HRESP_OKAY;
        end else begin
            state <= next_state;
        end
    end

    assign hreadyout = state.ready;
    assign hresp = state.resp;
    assign hrdata = state.rdata;

    // ------------------------------------------------------------
    // request crossing into the link domain
    // ------------------------------------------------------------
    logic [NUM_REQ-1:0] req_link;   // requests settled on lclk

    // requests are slow levels, so per-bit sync is enough for the frame encoder
    level_sync #(
        .WIDTH(NUM_REQ)
    ) u_req_sync (
        .clk(lclk),
        .rst_n(hresetn),
        .async_in(state.req),
        .sync_out(req_link)
    );

    assign host_irq11_req = req_link[REQ_IRQ11];
    assign host_irq10_req = req_link[REQ_IRQ10];
    assign host_irq9_req = req_link[REQ_IRQ9];
    assign host_irq6_req = req_link[REQ_IRQ6];

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    // channel 3 flag clear while not in direct mode
    sequence ch3_clear_s;
        !interrupt_direct_mode && ch3_fall;
    endsequence

    // channel 3 flag clear while in direct mode, nothing else touching the bit
    sequence ch3_clear_direct_s;
        interrupt_direct_mode && ch3_fall && !lpc_rst && !wr_ctl;
    endsequence

    irq11_ch3_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!interrupt_direct_mode && state.en[CH3_IRQ11_ENABLE] && ch3_out_buffer_full)
        |=> state.req[REQ_IRQ11])
        else $error("irq11 not raised by channel 3");

    irq10_ch3_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!interrupt_direct_mode && state.en[CH3_IRQ10_ENABLE] && ch3_out_buffer_full)
        |=> state.req[REQ_IRQ10])
        else $error("irq10 not raised by channel 3");

    irq9_ch3_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!interrupt_direct_mode && state.en[CH3_IRQ9_ENABLE] && ch3_out_buffer_full)
        |=> state.req[REQ_IRQ9])
        else $error("irq9 not raised by channel 3");

    irq6_ch3_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!interrupt_direct_mode && state.en[CH3_IRQ6_ENABLE] && ch3_out_buffer_full)
        |=> state.req[REQ_IRQ6])
        else $error("irq6 not raised by channel 3");

    irq11_ch2_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!interrupt_direct_mode && state.en[CH2_IRQ11_ENABLE] && ch2_out_buffer_full)
        |=> state.req[REQ_IRQ11])
        else $error("irq11 not raised by channel 2");

    direct_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (interrupt_direct_mode && state.en[CH3_IRQ9_ENABLE] && !ch3_out_buffer_full)
        |=> state.req[REQ_IRQ9])
        else $error("direct mode enable did not request irq9");

    enable_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !state.en[CH3_IRQ10_ENABLE] |=> !state.req[REQ_IRQ10])
        else $error("irq10 requested with enable off");

    write_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_ctl && !hwdata[CH3_IRQ6_ENABLE]) |=> !state.en[CH3_IRQ6_ENABLE])
        else $error("write of zero left enable set");

    lpc_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
        lpc_rst |=> (state.en == 8'h00) [*2])
        else $error("enables not cleared under lpc reset");

    flag_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ch3_clear_s |=> !state.en[CH3_IRQ11_ENABLE])
        else $error("flag clear left enable set");

    flag_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ch3_clear_direct_s |=> $stable(state.en[CH3_IRQ11_ENABLE]))
        else $error("direct mode flag clear changed enable");

    set_after_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(state.en[CH3_IRQ9_ENABLE]) |-> $past(state.armed[CH3_IRQ9_ENABLE]))
        else $error("enable set without prior read of zero");

    irq_combine_a: assert property (@(posedge hclk) disable iff (!hresetn)
        state.req[REQ_IRQ11] |-> $past((state.en[CH3_IRQ11_ENABLE] && src3)
            || (state.en[CH2_IRQ11_ENABLE] && src2)))
        else $error("irq11 raised with no enabled source");

    link_follow_a: assert property (@(posedge lclk) disable iff (!hresetn)
        $rose(state.req[REQ_IRQ11]) ##1 state.req[REQ_IRQ11] [*3] |-> ##[0:1] host_irq11_req)
        else $error("irq11 did not reach the link domain");

endmodule

`default_nettype wire

//--- lpc_host_model.sv
// behavioural model of the lpc host chipset that receives the serial interrupt requests
`timescale 1ns/1ns
`default_nettype none

module lpc_host_model (
    // link clock
    input wire logic lclk,
    // commands from the bench to pulse the lpc resets
    input wire logic hw_reset_cmd,
    input wire logic sw_reset_cmd,
    // requests arriving from the device
    input wire logic host_irq11_req,
    input wire logic host_irq10_req,
    input wire logic host_irq9_req,
    input wire logic host_irq6_req,
    // resets driven toward the device
    output logic lpc_hw_reset_n,
    output logic lpc_sw_reset,
    // requests as the host saw them, order irq11 irq10 irq9 irq6
    output logic [3:0] irq_seen
);
    // --------------------------------------------------------
    // the host samples request lines and drives the lpc resets, which clear the enables
    // --------------------------------------------------------
    always @(posedge lclk) begin
        lpc_hw_reset_n <= !hw_reset_cmd;
        lpc_sw_reset <= sw_reset_cmd;
        irq_seen <= {host_irq11_req, host_irq10_req, host_irq9_req, host_irq6_req};
    end
endmodule

`default_nettype wire

//--- sirq_enable_tb.sv
// self-checking testbench of the serial interrupt enable block
`timescale 1ns/1ns
`default_nettype none

module sirq_enable_tb;
    import sirq_enable_pkg::*;
    // --------------------------------------------------------
    // signals
    // --------------------------------------------------------
    typedef struct packed {logic f3; logic f2; logic dm; logic [7:0] en; logic [3:0] req;} row_t;
    localparam row_t ROWS [9] = '{'{1'b1, 1'b0, 1'b0, 8'h80, 4'h8}, '{1'b1, 1'b0, 1'b0, 8'h40, 4'h4},
        '{1'b1, 1'b0, 1'b0, 8'h20, 4'h2}, '{1'b1, 1'b0, 1'b0, 8'h10, 4'h1}, '{1'b0, 1'b1, 1'b0, 8'h08, 4'h8},
        '{1'b0, 1'b0, 1'b1, 8'hF8, 4'hF}, '{1'b1, 1'b1, 1'b0, 8'h00, 4'h0}, '{1'b0, 1'b1, 1'b0, 8'hF0, 4'h0},
        '{1'b1, 1'b1, 1'b0, 8'h88, 4'h8}};
    localparam logic [31:0] EN_ADDR = {24'h000000, OFS_SERIAL_IRQ_CONTROL_ONE};
    logic hclk = 1'b0;
    logic lclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h00000000;
    logic f3 = 1'b0;
    logic f2 = 1'b0;
    logic dm = 1'b0;
    logic hw_cmd = 1'b0;
    logic sw_cmd = 1'b0;
    logic hready;
    logic hresp;
    logic [31:0] hrdata;
    logic lpc_hw_reset_n;
    logic lpc_sw_reset;
    logic irq11, irq10, irq9, irq6;
    logic [3:0] seen;
    int err_total = 0;
    int checks_done = 0;

    // --------------------------------------------------------
    // clocks: link clock free running, unrelated phase
    // --------------------------------------------------------
    initial begin
        forever #25 hclk = ~hclk;
    end
    initial begin
        #7;
        forever #16 lclk = ~lclk;
    end

    // --------------------------------------------------------
    // design and host model
    // --------------------------------------------------------
    sirq_enable i_sirq_enable (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
        .hrdata(hrdata), .ch3_out_buffer_full(f3), .ch2_out_buffer_full(f2), .interrupt_direct_mode(dm),
        .lclk(lclk), .lpc_hw_reset_n(lpc_hw_reset_n), .lpc_sw_reset(lpc_sw_reset), .host_irq11_req(irq11),
        .host_irq10_req(irq10), .host_irq9_req(irq9), .host_irq6_req(irq6));
    lpc_host_model i_lpc_host_model (.lclk(lclk), .hw_reset_cmd(hw_cmd), .sw_reset_cmd(sw_cmd),
        .host_irq11_req(irq11), .host_irq10_req(irq10), .host_irq9_req(irq9), .host_irq6_req(irq6),
        .lpc_hw_reset_n(lpc_hw_reset_n), .lpc_sw_reset(lpc_sw_reset), .irq_seen(seen));

    // --------------------------------------------------------
    // tasks
    // --------------------------------------------------------
    task automatic print_verdict;
        $display("mismatches %0d of %0d checks", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, got, exp);
        end
    endtask
    // bounded wait for a rising edge that samples hready high
    task automatic bus_wait;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 16);
        if (hready !== 1'b1) begin
            err_total++;
            print_verdict();
        end
    endtask
    task automatic xfer(input logic [31:0] a, input logic is_wr, input logic [31:0] wd, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= is_wr;
        bus_wait();
        htrans <= 2'b00;
        hwdata <= wd;
        bus_wait();
        q = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(a, 1'b1, d, q);
    endtask
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] q;
        xfer(a, 1'b0, 32'h00000000, q);
        check(q, exp);
    endtask
    // reading zero first arms the bits, so the write of ones takes
    task automatic set_en(input logic [7:0] v);
        logic [31:0] q;
        xfer(EN_ADDR, 1'b0, 32'h00000000, q);
        wr(EN_ADDR, {24'h000000, v});
    endtask
    // request path crosses into lclk, a few link edges
    task automatic settle;
        repeat (12) @(posedge hclk);
    endtask

    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk(EN_ADDR, 32'h00000000);
        foreach (ROWS[i]) begin
            f3 <= ROWS[i].f3;
            f2 <= ROWS[i].f2;
            dm <= ROWS[i].dm;
            set_en(ROWS[i].en);
            settle();
            check({28'h0000000, seen}, {28'h0000000, ROWS[i].req});
            rd_chk(EN_ADDR, {24'h000000, ROWS[i].en & 8'hF8});
            wr(EN_ADDR, 32'h00000000);
            rd_chk(EN_ADDR, 32'h00000000);
        end
        // flags and mode back to idle once, after the last row
        f3 <= 1'b0;
        f2 <= 1'b0;
        dm <= 1'b0;
        // a write of ones with no read in between must not set
        wr(EN_ADDR, 32'h00000000);
        wr(EN_ADDR, 32'h000000F8);
        rd_chk(EN_ADDR, 32'h00000000);
        wr(EN_ADDR, 32'h000000F8);
        rd_chk(EN_ADDR, 32'h000000F8);
        // flag clear drops enables only outside direct mode
        f3 <= 1'b1;
        f2 <= 1'b1;
        settle();
        rd_chk({24'h000000, OFS_IRQ_STATUS}, 32'h000000F3);
        f3 <= 1'b0;
        settle();
        rd_chk(EN_ADDR, 32'h00000008);
        f2 <= 1'b0;
        settle();
        rd_chk(EN_ADDR, 32'h00000000);
        dm <= 1'b1;
        f3 <= 1'b1;
        f2 <= 1'b1;
        set_en(8'hF8);
        f3 <= 1'b0;
        f2 <= 1'b0;
        settle();
        rd_chk(EN_ADDR, 32'h000000F8);
        check({28'h0000000, seen}, 32'h0000000F);
        // lpc hardware then software reset clear everything
        hw_cmd <= 1'b1;
        settle();
        hw_cmd <= 1'b0;
        settle();
        rd_chk(EN_ADDR, 32'h00000000);
        check({28'h0000000, seen}, 32'h00000000);
        set_en(8'hF8);
        sw_cmd <= 1'b1;
        settle();
        sw_cmd <= 1'b0;
        settle();
        rd_chk(EN_ADDR, 32'h00000000);
        // unmapped place reads zero and ignores writes
        wr(32'h00000008, 32'h000000FF);
        rd_chk(32'h00000008, 32'h00000000);
        check({31'h00000000, hresp}, {31'h00000000, HRESP_OKAY});
        // bus reset in mid-run
        set_en(8'hF8);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk(EN_ADDR, 32'h00000000);
        settle();
        check({28'h0000000, seen}, 32'h00000000);
        print_verdict();
    end
endmodule

`default_nettype wire
